// *** dv/caw_drive_model.sv ***
/*
 Behavioural drive on the far side of the port-1 window.
 Assumes selects and write strobe are registered levels from the block.
*/
`timescale 1ns/1ps
`default_nettype none
module caw_drive_model #(
	parameter logic [15:0] READ_WORD = 16'ha55a
) (
	input  wire logic        clk_in,    // Block clock.
	input  wire logic        sel_a_in,  // First drive select.
	input  wire logic        sel_b_in,  // Second drive select.
	input  wire logic        write_in,  // Write level.
	input  wire logic [15:0] wdata_in,  // Write data.
	output logic [15:0]      rdata_out, // Read data.
	output logic [15:0]      cap_out    // Last word written.
);
	// The drive answers only while selected; otherwise the inverse, so stale data never passes.
	assign rdata_out = (sel_a_in | sel_b_in) ? READ_WORD : ~READ_WORD;
	// Latch the word a selected write hands over.
	always_ff @(posedge clk_in)
	begin
		if ((sel_a_in | sel_b_in) & write_in)
			cap_out <= wdata_in;
	end
endmodule
`default_nettype wire

// *** dv/tb.sv ***
/*
 Self-checking bench for the card adapter window register bank.
 Assumes the drive model of caw_drive_model.sv and a 25 ns clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic                  sys_clk_in;
	logic                  nrst_in;
	caw_pkg::caw_bus_type  bus;
	caw_pkg::caw_card_type card;
	logic [7:0]            rdata;
	logic                  strap, crst, pdiag, dasp, guard, spk;
	logic                  ack, wt, sel_a, sel_b, dwr, dack, dreq, drst;
	logic [15:0]           crd, drd, dwd, cap;
	logic                  s_a, s_b, s_w, s_d;
	int                    mismatches;
	int                    total_checks;
	int                    n;
	int                    nw;
	logic [7:0]            v;

	// ------------------------------------------------------------
	// Design and drive model
	// ------------------------------------------------------------
	caw_regs dut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .bus_in(bus), .rdata_out(rdata),
		.mode_strap_pin_in(strap), .card_reset_in(crst), .pdiag_in(pdiag), .dasp_in(dasp),
		.pin_write_guard_in(guard), .speaker_dreq_in(spk), .card_in(card),
		.card_ack_out(ack), .card_wait_out(wt), .card_rdata_out(crd), .drive_rdata_in(drd),
		.drive_wdata_out(dwd), .drive_select_a_out(sel_a), .drive_select_b_out(sel_b),
		.drive_write_out(dwr), .drive_dma_ack_out(dack), .drive_dreq_out(dreq),
		.drive_reset_out(drst));
	caw_drive_model drv (.clk_in(sys_clk_in), .sel_a_in(sel_a), .sel_b_in(sel_b),
		.write_in(dwr), .wdata_in(dwd), .rdata_out(drd), .cap_out(cap));

	// Clock at 40 MHz.
	initial
	begin
		sys_clk_in = 1'b0;
		forever #12.5 sys_clk_in = ~sys_clk_in;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_in);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge sys_clk_in);
		bus.wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk_in);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge sys_clk_in);
		bus.rd <= 1'b0;
		#1 v = rdata;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		rd(a);
		chk($sformatf("reg %h", a), {8'h00, v}, {8'h00, exp});
	endtask

	// Hold a card access until ack or 12 cycles; n is the cycle ack showed, 0 if none.
	// The count nw holds the cycles in which the wait output stood high.
	task automatic card_go(input logic mem, input logic w, input logic [10:0] a,
		input logic [15:0] d);
		n = 0;
		nw = 0;
		{s_a, s_b, s_w, s_d} = 4'h0;
		@(posedge sys_clk_in);
		card <= '{1'b1, mem, w, a, d};
		for (int i = 1; i <= 12 && n == 0; i++)
		begin
			@(posedge sys_clk_in);
			#1;
			{s_a, s_b, s_w, s_d} = {s_a, s_b, s_w, s_d} | {sel_a, sel_b, dwr, dack};
			if (wt === 1'b1)
				nw++;
			if (ack === 1'b1)
				n = i;
		end
		@(posedge sys_clk_in);
		card.req <= 1'b0;
	endtask

	task automatic pins(input logic c, input logic d);
		@(posedge sys_clk_in);
		crst <= c;
		dasp <= d;
		repeat (4) @(posedge sys_clk_in);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_status();
		rd(caw_pkg::OFS_EXCEPTION_STATUS);
		chk("sample valid early", {15'h0, v[7]}, 16'h0000);
		repeat (4) @(posedge sys_clk_in);
		rchk(8'h07, 8'ha0);
		wr(8'h07, 8'hff);
		rchk(8'h07, 8'ha0);
		rchk(8'h10, 8'h01);
		rchk(8'h08, 8'h00);
		rchk(8'h3f, 8'h00);
		pins(1'b1, 1'b1);
		rchk(8'h07, 8'he2);
		chk("drive reset card mode", drst, 16'h0000);
		pins(1'b0, 1'b0);
		chk("drive reset idle", drst, 16'h0001);
	endtask

	task automatic t_attr();
		wr(8'h08, 8'h05);
		wr(8'h09, 8'haa);
		wr(8'h09, 8'h55);
		wr(8'h08, 8'hff);
		wr(8'h09, 8'h3c);
		wr(8'h09, 8'hc3);
		wr(8'h08, 8'h05);
		rchk(8'h09, 8'haa);
		rchk(8'h09, 8'h55);
		wr(8'h08, 8'hff);
		rchk(8'h09, 8'h3c);
		rchk(8'h09, 8'hc3);
	endtask

	task automatic t_wait();
		logic [3:0] w [4] = '{caw_pkg::WAIT_COUNT_0, caw_pkg::WAIT_COUNT_1,
			caw_pkg::WAIT_COUNT_2, caw_pkg::WAIT_COUNT_3};
		for (int k = 0; k < 4; k++)
		begin
			wr(8'h10, {k[1:0], 6'h00});
			card_go(1'b0, 1'b0, 11'h1f0, 16'h0000);
			chk("ack cycle", 16'(n), 16'(w[k]) + 16'h2);
			chk("wait level", 16'(nw), 16'(w[k]) + 16'h1);
			chk("select a", {14'h0, s_a, s_b}, 16'h0002);
			chk("plain read", crd, 16'ha55a);
		end
	endtask

	task automatic t_window();
		wr(8'h10, 8'h01);
		card_go(1'b0, 1'b0, 11'h1f0, 16'h0000);
		chk("disabled", 16'(n), 16'h0000);
		wr(8'h10, 8'h02);
		card_go(1'b0, 1'b0, 11'h1f0, 16'h0000);
		chk("io refused", 16'(n), 16'h0000);
		card_go(1'b1, 1'b0, 11'h1f0, 16'h0000);
		chk("mem taken", 16'(n), 16'h0002);
		wr(8'h10, 8'h08);
		card_go(1'b0, 1'b0, 11'h1f0, 16'h0000);
		chk("protected", 16'(n), 16'h0000);
		wr(8'h10, 8'h24);
		card_go(1'b0, 1'b1, 11'h1f0, 16'h1234);
		chk("swap write", cap, 16'h3412);
		chk("select b", {14'h0, s_a, s_b}, 16'h0001);
		card_go(1'b0, 1'b0, 11'h1f0, 16'h0000);
		chk("swap read", crd, 16'h5aa5);
		wr(8'h11, 8'h00);
		wr(8'h12, 8'h81);
		wr(8'h13, 8'h10);
		wr(8'h10, 8'h10);
		rchk(8'h12, 8'h81);
		card_go(1'b0, 1'b0, 11'h110, 16'h0000);
		chk("window top", 16'(n), 16'h0002);
		chk("dma ack", {15'h0, s_d}, 16'h0001);
		card_go(1'b0, 1'b0, 11'h111, 16'h0000);
		chk("above window", 16'(n), 16'h0000);
		card_go(1'b0, 1'b0, 11'h0ff, 16'h0000);
		chk("below window", 16'(n), 16'h0000);
		@(posedge sys_clk_in);
		spk <= 1'b1;
		repeat (4) @(posedge sys_clk_in);
		chk("dma request", {15'h0, dreq}, 16'h0001);
	endtask

	task automatic t_guard();
		wr(8'h12, 8'h08);
		wr(8'h10, 8'h00);
		@(posedge sys_clk_in);
		guard <= 1'b1;
		repeat (4) @(posedge sys_clk_in);
		card_go(1'b0, 1'b1, 11'h1f0, 16'h0000);
		chk("guarded write", {15'h0, s_w}, 16'h0000);
		wr(8'h12, 8'h00);
		card_go(1'b0, 1'b1, 11'h1f0, 16'h1234);
		chk("guard ignored", {15'h0, s_w}, 16'h0001);
		chk("plain write", cap, 16'h1234);
	endtask

	task automatic t_mode();
		wr(caw_pkg::OFS_MODE_CONTROL, 8'h03);
		repeat (4) @(posedge sys_clk_in);
		rchk(8'h07, 8'ha1);
		chk("drive mode reset", drst, 16'h0000);
		pins(1'b1, 1'b0);
		chk("drive mode run", drst, 16'h0001);
		pins(1'b0, 1'b0);
		wr(caw_pkg::OFS_MODE_CONTROL, 8'h07);
		// The write lands at the edge the task returns on; look once it has settled.
		@(negedge sys_clk_in);
		chk("reset disabled", drst, 16'h0001);
	endtask

	// Reset again in mid-run with the strap high: drive mode must be caught.
	task automatic t_strap();
		@(posedge sys_clk_in);
		strap <= 1'b1;
		nrst_in <= 1'b0;
		repeat (5) @(posedge sys_clk_in);
		nrst_in <= 1'b1;
		rd(caw_pkg::OFS_EXCEPTION_STATUS);
		chk("strap not ready", {15'h0, v[7]}, 16'h0000);
		repeat (4) @(posedge sys_clk_in);
		rchk(8'h07, 8'ha1);
		chk("strap mode reset", drst, 16'h0000);
		rchk(8'h10, 8'h01);
	endtask

	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial
	begin
		bus = '0;
		card = '0;
		nrst_in = 1'b0;
		{strap, crst, pdiag, dasp, guard, spk} = 6'b001000;
		repeat (5) @(posedge sys_clk_in);
		nrst_in <= 1'b1;
		t_status();
		t_attr();
		t_wait();
		t_window();
		t_guard();
		t_mode();
		t_strap();
		wrap_up();
	end

	initial
	begin
		repeat (20000) @(posedge sys_clk_in);
		mismatches++;
		wrap_up();
	end
endmodule
`default_nettype wire

// *** hw/caw_regs.sv ***
/*
 Card adapter window register bank with attribute memory port and port-1
 window decoder. Assumes synchronous register strobes from sys_clk_in logic,
 and that card and drive pins arrive asynchronously.
*/
// Implementation choice: the strobed register port.
//
// Functional notes
// - Status bit 0 shows drive mode, from strap at reset or override.
// - Status bit 7 sets once mode sampling completes; before that not ready.
// - Status bit 1 reads one while the card reset is active.
// - Status bit 5 shows PDIAG present; bits 2 to 4 read zero.
// - Status bit 6 shows DASP detected.
// - Pointer register at 08h is write only and addresses attribute memory.
// - Control bit 0 set disables the port-1 decoder.
// - Control bit 1 picks memory space when set, I/O space when clear.
// - Control bit 2 swaps drive low byte and host high byte.
// - Control bit 3 keeps the card bus from going active.
// - Control bit 5 picks second drive select, else the first.
// - Control bits 7-6 give 0, 3, 5 or 7 wait clock periods.
// - Register 11h holds start address low byte.
// - Register 12h bits 2-0 start high, bits 6-4 range high.
// - Register 13h holds range address low byte.
// - Drive reset follows reset disable, card reset input and mode bit.
`timescale 1ns/1ps
`default_nettype none
module caw_regs #(
	parameter int ATTR_DEPTH = 256
) (
	input  wire logic                  sys_clk_in,        // 40 MHz clock.
	input  wire logic                  nrst_in,           // Async reset, low.
	input  wire caw_pkg::caw_bus_type  bus_in,            // Register strobes.
	output logic [7:0]                 rdata_out,         // Read data.
	input  wire logic                  mode_strap_pin_in, // Mode strap pin.
	input  wire logic                  card_reset_in,     // Card reset pin.
	input  wire logic                  pdiag_in,          // Drive PDIAG, high.
	input  wire logic                  dasp_in,           // Drive DASP, high.
	input  wire logic                  pin_write_guard_in,// Write guard bit.
	input  wire logic                  speaker_dreq_in,   // Speaker as DREQ.
	input  wire caw_pkg::caw_card_type card_in,           // Card access.
	output logic                       card_ack_out,      // Access taken.
	output logic                       card_wait_out,     // Wait states.
	output logic [15:0]                card_rdata_out,    // Host read data.
	input  wire logic [15:0]           drive_rdata_in,    // Drive data.
	output logic [15:0]                drive_wdata_out,   // Drive write data.
	output logic                       drive_select_a_out,// First select.
	output logic                       drive_select_b_out,// Second select.
	output logic                       drive_write_out,   // Drive write.
	output logic                       drive_dma_ack_out, // DMA acknowledge.
	output logic                       drive_dreq_out,    // DMA request.
	output logic                       drive_reset_out    // Drive reset, low.
);
	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic [5:0] sync1;
	logic [5:0] sync2;
	logic       strap_s;
	logic       crst_s;
	logic       pdiag_s;
	logic       dasp_s;
	logic       guard_s;
	logic       dreq_s;

	// Two flops for every asynchronous pin.
	always_ff @(posedge sys_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			sync1 <= 6'h00;
			sync2 <= 6'h00;
		end
		else
		begin
			sync1 <= {speaker_dreq_in, pin_write_guard_in, dasp_in, pdiag_in,
				card_reset_in, mode_strap_pin_in};
			sync2 <= sync1;
		end
	end
	assign {dreq_s, guard_s, dasp_s, pdiag_s, crst_s, strap_s} = sync2;

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic [7:0] attr_mem [ATTR_DEPTH];
	logic [7:0] pointer, next_pointer;
	logic [7:0] control, next_control;
	logic [7:0] start_low, next_start_low;
	logic [7:0] addr_high, next_addr_high;
	logic [7:0] range_low, next_range_low;
	logic [7:0] mode_ctl, next_mode_ctl;
	logic [1:0] sample_cnt, next_sample_cnt;
	logic       strap_mode, next_strap_mode;
	logic       sampled, next_sampled;
	logic [7:0] next_rdata;
	logic       drive_mode;
	logic [7:0] status;

	// Mode flag: override when enabled, else the strap value caught at release.
	assign drive_mode = mode_ctl[caw_pkg::BIT_OVR_ENABLE] ?
		mode_ctl[caw_pkg::BIT_OVR_MODE] : strap_mode;

	// Status byte; reserved bits stay zero.
	always_comb
	begin
		status = 8'h00;
		status[caw_pkg::BIT_MODE_FLAG]    = drive_mode;
		status[caw_pkg::BIT_RESET_STATUS] = crst_s;
		status[caw_pkg::BIT_PDIAG]        = pdiag_s;
		status[caw_pkg::BIT_DASP]         = dasp_s;
		status[caw_pkg::BIT_SAMPLE_VALID] = sampled;
	end

	// Next values for registers, strap sampling and read data.
	always_comb
	begin
		next_pointer    = pointer;
		next_control    = control;
		next_start_low  = start_low;
		next_addr_high  = addr_high;
		next_range_low  = range_low;
		next_mode_ctl   = mode_ctl;
		next_sample_cnt = sample_cnt;
		next_strap_mode = strap_mode;
		next_sampled    = sampled;
		next_rdata      = 8'h00;
		// The strap passes the synchroniser before it is caught.
		if (!sampled)
		begin
			if (sample_cnt == caw_pkg::SAMPLE_DELAY)
			begin
				next_strap_mode = strap_s;
				next_sampled    = 1'b1;
			end
			else
				next_sample_cnt = sample_cnt + 2'h1;
		end
		if (bus_in.wr)
		begin
			unique case (bus_in.addr)
				caw_pkg::OFS_ATTR_MEM_POINTER: next_pointer = bus_in.wdata;
				caw_pkg::OFS_ATTR_MEM_DATA:    next_pointer = pointer + 8'h01;
				caw_pkg::OFS_PORT1_CONTROL:    next_control = bus_in.wdata;
				caw_pkg::OFS_PORT1_START_LOW:  next_start_low = bus_in.wdata;
				caw_pkg::OFS_PORT1_ADDR_HIGH:  next_addr_high = bus_in.wdata;
				caw_pkg::OFS_PORT1_RANGE_LOW:  next_range_low = bus_in.wdata;
				caw_pkg::OFS_MODE_CONTROL:     next_mode_ctl = bus_in.wdata;
				default:                       next_pointer = pointer;
			endcase
		end
		else if (bus_in.rd)
		begin
			unique case (bus_in.addr)
				caw_pkg::OFS_EXCEPTION_STATUS: next_rdata = status;
				caw_pkg::OFS_ATTR_MEM_DATA:
				begin
					next_rdata   = attr_mem[pointer];
					next_pointer = pointer + 8'h01;
				end
				caw_pkg::OFS_PORT1_CONTROL:    next_rdata = control;
				caw_pkg::OFS_PORT1_START_LOW:  next_rdata = start_low;
				caw_pkg::OFS_PORT1_ADDR_HIGH:  next_rdata = addr_high;
				caw_pkg::OFS_PORT1_RANGE_LOW:  next_rdata = range_low;
				caw_pkg::OFS_MODE_CONTROL:     next_rdata = mode_ctl;
				default:                       next_rdata = 8'h00;
			endcase
		end
	end

	// Register the bank state.
	always_ff @(posedge sys_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			pointer    <= caw_pkg::RST_REG;
			control    <= caw_pkg::RST_CONTROL;
			start_low  <= caw_pkg::RST_REG;
			addr_high  <= caw_pkg::RST_REG;
			range_low  <= caw_pkg::RST_REG;
			mode_ctl   <= caw_pkg::RST_REG;
			sample_cnt <= 2'h0;
			strap_mode <= 1'b0;
			sampled    <= 1'b0;
			rdata_out  <= 8'h00;
		end
		else
		begin
			pointer    <= next_pointer;
			control    <= next_control;
			start_low  <= next_start_low;
			addr_high  <= next_addr_high;
			range_low  <= next_range_low;
			mode_ctl   <= next_mode_ctl;
			sample_cnt <= next_sample_cnt;
			strap_mode <= next_strap_mode;
			sampled    <= next_sampled;
			rdata_out  <= next_rdata;
		end
	end

	// Attribute memory has no reset; data writes store at the pointer.
	always_ff @(posedge sys_clk_in)
	begin
		if (bus_in.wr && bus_in.addr == caw_pkg::OFS_ATTR_MEM_DATA)
			attr_mem[pointer] <= bus_in.wdata;
	end

	// ------------------------------------------------------------
	// Port-1 window decoder
	// ------------------------------------------------------------
	logic [10:0] win_start;
	logic [10:0] win_range;
	logic [11:0] win_end;
	logic        in_window;
	logic        space_ok;
	logic        hit;
	logic        write_blocked;
	logic [3:0]  wait_load;

	// Map the two wait bits onto the clock counts.
	function automatic logic [3:0] wait_of(input logic [1:0] code);
		unique case (code)
			2'b00: wait_of = caw_pkg::WAIT_COUNT_0;
			2'b01: wait_of = caw_pkg::WAIT_COUNT_1;
			2'b10: wait_of = caw_pkg::WAIT_COUNT_2;
			2'b11: wait_of = caw_pkg::WAIT_COUNT_3;
		endcase
	endfunction

	// Window bounds and hit terms.
	assign win_start = {addr_high[2:0], start_low};
	assign win_range = {addr_high[6:4], range_low};
	assign win_end   = {1'b0, win_start} + {1'b0, win_range};
	assign in_window = ({1'b0, card_in.addr} >= {1'b0, win_start}) &&
		({1'b0, card_in.addr} <= win_end);
	assign space_ok  = card_in.is_mem == control[caw_pkg::BIT_MEM_SPACE];
	assign hit = card_in.req && !control[caw_pkg::BIT_DEC_DISABLE] && space_ok &&
		(!control[caw_pkg::BIT_COMPARE_EN] || in_window);
	assign write_blocked = card_in.is_write && addr_high[caw_pkg::BIT_WRITE_GUARD] &&
		guard_s;
	assign wait_load = wait_of(control[7:caw_pkg::BIT_WAIT_LO]);

	logic [3:0]  wait_cnt, next_wait_cnt;
	logic        busy, next_busy;
	logic        next_ack;
	logic        next_sel_a;
	logic        next_sel_b;
	logic        next_dwr;
	logic        next_dack;
	logic [15:0] next_card_rdata;
	logic [15:0] next_drive_wdata;

	// One access at a time: wait states, then acknowledge.
	always_comb
	begin
		next_wait_cnt    = wait_cnt;
		next_busy        = busy;
		next_ack         = 1'b0;
		next_sel_a       = 1'b0;
		next_sel_b       = 1'b0;
		next_dwr         = 1'b0;
		next_dack        = 1'b0;
		next_card_rdata  = card_rdata_out;
		next_drive_wdata = drive_wdata_out;
		if (busy)
		begin
			next_sel_a = drive_select_a_out;
			next_sel_b = drive_select_b_out;
			next_dwr   = drive_write_out;
			next_dack  = drive_dma_ack_out;
			if (wait_cnt == 4'h0)
			begin
				next_busy = 1'b0;
				// Read protect keeps the card bus from going active.
				next_ack  = !control[caw_pkg::BIT_READ_PROTECT];
				if (control[caw_pkg::BIT_BYTE_SWAP])
					next_card_rdata = {drive_rdata_in[7:0], drive_rdata_in[15:8]};
				else
					next_card_rdata = drive_rdata_in;
			end
			else
				next_wait_cnt = wait_cnt - 4'h1;
		end
		else if (hit && !card_ack_out)
		begin
			next_busy     = 1'b1;
			next_wait_cnt = wait_load;
			next_sel_a    = !control[caw_pkg::BIT_CS_CHOICE];
			next_sel_b    = control[caw_pkg::BIT_CS_CHOICE];
			next_dwr      = card_in.is_write && !write_blocked;
			next_dack     = addr_high[caw_pkg::BIT_DMA_ACK_EN];
			if (control[caw_pkg::BIT_BYTE_SWAP])
				next_drive_wdata = {card_in.wdata[7:0], card_in.wdata[15:8]};
			else
				next_drive_wdata = card_in.wdata;
		end
	end

	// Register the decoder state.
	always_ff @(posedge sys_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			wait_cnt           <= 4'h0;
			busy               <= 1'b0;
			card_ack_out       <= 1'b0;
			drive_select_a_out <= 1'b0;
			drive_select_b_out <= 1'b0;
			drive_write_out    <= 1'b0;
			drive_dma_ack_out  <= 1'b0;
			card_rdata_out     <= 16'h0000;
			drive_wdata_out    <= 16'h0000;
		end
		else
		begin
			wait_cnt           <= next_wait_cnt;
			busy               <= next_busy;
			card_ack_out       <= next_ack;
			drive_select_a_out <= next_sel_a;
			drive_select_b_out <= next_sel_b;
			drive_write_out    <= next_dwr;
			drive_dma_ack_out  <= next_dack;
			card_rdata_out     <= next_card_rdata;
			drive_wdata_out    <= next_drive_wdata;
		end
	end

	// Wait is shown while an access is held; DMA request follows speaker out while the DMA ack enable bit is set.
	assign card_wait_out  = busy;
	assign drive_dreq_out = addr_high[caw_pkg::BIT_DMA_ACK_EN] && dreq_s;

	// Drive reset, active low: idle when disabled, asserted per mode.
	assign drive_reset_out = mode_ctl[caw_pkg::BIT_RESET_DISABLE] ? 1'b1 :
		(drive_mode ? crst_s : !crst_s);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	ptr_advance_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		(bus_in.rd && bus_in.addr == caw_pkg::OFS_ATTR_MEM_DATA) |=>
		pointer == $past(pointer) + 8'h01)
		else $error("Pointer did not advance after data read.");
	ptr_write_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		(bus_in.wr && bus_in.addr == caw_pkg::OFS_ATTR_MEM_POINTER) |=>
		pointer == $past(bus_in.wdata) ##1 1'b1)
		else $error("Pointer write not stored.");
	ptr_readback_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		(bus_in.rd && bus_in.addr == caw_pkg::OFS_ATTR_MEM_POINTER) |=> rdata_out == 8'h00)
		else $error("Pointer register read back data.");
	sample_done_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		$rose(nrst_in) || !sampled |-> ##[0:4] sampled)
		else $error("Mode sample never completed.");
	status_read_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		(bus_in.rd && bus_in.addr == caw_pkg::OFS_EXCEPTION_STATUS) |=>
		rdata_out[4:2] == 3'h0 && rdata_out[7] == $past(sampled) &&
		rdata_out[1] == $past(crst_s) && rdata_out[6] == $past(dasp_s) &&
		rdata_out[5] == $past(pdiag_s) && rdata_out[0] == $past(drive_mode))
		else $error("Status read mismatch.");
	disable_dec_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		(control[caw_pkg::BIT_DEC_DISABLE] && !busy) |=> !busy)
		else $error("Disabled decoder started an access.");
	wait_len_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		(!busy && next_busy && control[7:6] == 2'b10) |=> busy [*6] ##1 !busy)
		else $error("Wait length wrong for five periods.");
	read_prot_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		control[caw_pkg::BIT_READ_PROTECT] && $stable(control) |=> !card_ack_out)
		else $error("Card bus went active under read protect.");
	cs_choice_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		(!busy && next_busy) |=> drive_select_b_out == $past(control[5]) &&
		drive_select_a_out == !$past(control[5]))
		else $error("Wrong drive select chosen.");
	drive_rst_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		mode_ctl[caw_pkg::BIT_RESET_DISABLE] |-> drive_reset_out)
		else $error("Drive reset asserted while disabled.");
endmodule
`default_nettype wire

// *** pkg/caw_pkg.sv ***
/*
 Package for the card adapter window register bank: register offsets,
 field positions, reset values, wait-state counts and the carrier structs.
 Assumes a single 40 MHz clock domain and an 8-bit register port.
*/
`default_nettype none
package caw_pkg;
	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_EXCEPTION_STATUS = 8'h07;
	localparam logic [7:0] OFS_ATTR_MEM_POINTER = 8'h08;
	localparam logic [7:0] OFS_ATTR_MEM_DATA    = 8'h09;
	localparam logic [7:0] OFS_PORT1_CONTROL    = 8'h10;
	localparam logic [7:0] OFS_PORT1_START_LOW  = 8'h11;
	localparam logic [7:0] OFS_PORT1_ADDR_HIGH  = 8'h12;
	localparam logic [7:0] OFS_PORT1_RANGE_LOW  = 8'h13;
	localparam logic [7:0] OFS_MODE_CONTROL     = 8'h20;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BIT_MODE_FLAG     = 0;
	localparam int BIT_RESET_STATUS  = 1;
	localparam int BIT_PDIAG         = 5;
	localparam int BIT_DASP          = 6;
	localparam int BIT_SAMPLE_VALID  = 7;
	localparam int BIT_DEC_DISABLE   = 0;
	localparam int BIT_MEM_SPACE     = 1;
	localparam int BIT_BYTE_SWAP     = 2;
	localparam int BIT_READ_PROTECT  = 3;
	localparam int BIT_COMPARE_EN    = 4;
	localparam int BIT_CS_CHOICE     = 5;
	localparam int BIT_WAIT_LO       = 6;
	localparam int BIT_WRITE_GUARD   = 3;
	localparam int BIT_DMA_ACK_EN    = 7;
	localparam int BIT_OVR_ENABLE    = 0;
	localparam int BIT_OVR_MODE      = 1;
	localparam int BIT_RESET_DISABLE = 2;
	// ------------------------------------------------------------
	// Reset values and timing counts
	// ------------------------------------------------------------
	localparam logic [7:0] RST_REG          = 8'h00;
	localparam logic [7:0] RST_CONTROL      = 8'h01;
	localparam logic [3:0] WAIT_COUNT_0     = 4'h0;
	localparam logic [3:0] WAIT_COUNT_1     = 4'h3;
	localparam logic [3:0] WAIT_COUNT_2     = 4'h5;
	localparam logic [3:0] WAIT_COUNT_3     = 4'h7;
	localparam logic [1:0] SAMPLE_DELAY     = 2'h2;
	// ------------------------------------------------------------
	// Carrier structs
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} caw_bus_type;
	typedef struct packed {
		logic        req;
		logic        is_mem;
		logic        is_write;
		logic [10:0] addr;
		logic [15:0] wdata;
	} caw_card_type;
endpackage
`default_nettype wire
